// >>> common/rspi_defines.svh
`ifndef RSPI_DEFINES_SVH
`define RSPI_DEFINES_SVH

// ----------------------------------------------------------------------------
// Serial framing constants
// ----------------------------------------------------------------------------
// Short address form is used for addresses below this boundary.
`define RSPI_SHORT_LIMIT  8'h70
// Top three address bits of a first byte that announces the long form.
`define RSPI_LONG_MARK    3'h7
// Bit position of the read/write flag inside the first address byte.
`define RSPI_RW_BIT       7
// Width of the internal address counter (long form reaches 12 bits).
`define RSPI_ADDR_W       12
// Number of bytes held in the register bank.
`define RSPI_BANK_DEPTH   256
// Width of the buffer fill and free-space counts.
`define RSPI_LVL_W        9

// ----------------------------------------------------------------------------
// Wishbone register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define RSPI_OFS_LIMIT    8'h00
`define RSPI_OFS_STATUS   8'h04
`define RSPI_OFS_FRAMES   8'h08
`define RSPI_OFS_ADDR     8'h0C
`define RSPI_OFS_BSEL     8'h10
`define RSPI_OFS_BDATA    8'h14

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RSPI_LIMIT_RST    9'h080
`define RSPI_BSEL_RST     8'h00
// Synchroniser reset: frame strobe (bit 0) idles high, all else low.
`define RSPI_SYNC_RST     4'h1

`endif

// >>> common/rspi_pkg.sv
package rspi_pkg;

    // ------------------------------------------------------------------------
    // Serial frame phases
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        RSPI_IDLE  = 2'b00,
        RSPI_ADDR1 = 2'b01,
        RSPI_ADDR2 = 2'b10,
        RSPI_DATA  = 2'b11
    } rspi_state_t;

endpackage : rspi_pkg

// >>> hdl/rspi_sync.sv
`timescale 1ns/1ps
`include "rspi_defines.svh"

// ----------------------------------------------------------------------------
// Two-stage synchroniser for the serial pins and the power-ready level
// ----------------------------------------------------------------------------
module rspi_sync (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] async_i,
    output logic      [3:0] sync_o
);

    // First stage is read only by the second stage.
    logic [3:0] meta_r;
    // Second stage feeds the port logic.
    logic [3:0] sync_r;

    // Both stages load a constant on reset so the strobe reads idle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= `RSPI_SYNC_RST;
            sync_r <= `RSPI_SYNC_RST;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule : rspi_sync

// >>> hdl/rspi_port.sv
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "rspi_defines.svh"

module rspi_port
    import rspi_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Serial pins from the host.
    input  wire logic                   sel_n_i,
    input  wire logic                   sclk_i,
    input  wire logic                   mosi_i,
    output logic                        miso_o,
    // Internal power ready level, low while leaving the deepest off state.
    input  wire logic                   power_ready_i,
    // Status sources inside the device, same clock domain.
    input  wire logic                   pll_lock_i,
    input  wire logic                   buffer_overflow_i,
    input  wire logic                   buffer_full_i,
    input  wire logic                   buffer_empty_i,
    input  wire logic [`RSPI_LVL_W-1:0] buffer_fill_level_i,
    input  wire logic [`RSPI_LVL_W-1:0] buffer_space_left_i,
    input  wire logic                   supply_ok_i,
    input  wire logic                   power_irq_i,
    input  wire logic                   radio_event_i,
    input  wire logic                   xtal_running_i,
    input  wire logic                   wakeup_irq_i,
    input  wire logic                   slow_oscillator_irq_i,
    input  wire logic                   aux_converter_irq_i,
    // Classic Wishbone slave.
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Reverses a byte so that status cell 0 leaves first on the wire.
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < 8; k++) begin
            r[k] = v[7-k];
        end
        return r;
    endfunction : rev8

    // Next address of a burst, wrapping within the counter width.
    function automatic logic [`RSPI_ADDR_W-1:0] addr_inc(input logic [`RSPI_ADDR_W-1:0] a);
        return a + `RSPI_ADDR_W'(1);
    endfunction : addr_inc

    // ------------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------------
    logic [3:0]  sync_w;        // Synchronised {ready, mosi, sclk, sel_n}.
    logic        sel_n_s;       // Frame strobe, active low.
    logic        sclk_s;        // Serial clock level.
    logic        mosi_s;        // Serial data in.
    logic        rdy_s;         // Power ready level.
    logic        sclk_d_r;      // Serial clock one sample ago.

    rspi_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({power_ready_i, mosi_i, sclk_i, sel_n_i}),
        .sync_o  (sync_w)
    );

    assign sel_n_s = sync_w[0];
    assign sclk_s  = sync_w[1];
    assign mosi_s  = sync_w[2];
    assign rdy_s   = sync_w[3];

    // The previous clock sample turns levels into edges.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
        end
    end

    // ------------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------------
    rspi_state_t                state_r;     // Phase of the current frame.
    logic [2:0]                 bit_cnt_r;   // Bits received in this byte.
    logic [7:0]                 sh_in_r;     // Incoming shift register.
    logic [7:0]                 out_sh_r;    // Outgoing shift register.
    logic [7:0]                 pend_r;      // Byte to send after boundary.
    logic                       wr_r;        // Frame is a write.
    logic [`RSPI_ADDR_W-1:0]    addr_r;      // Internal address counter.
    logic [15:0]                stat_snap_r; // Status frozen at frame start.
    logic [7:0]                 bank_r [`RSPI_BANK_DEPTH]; // Register bank.
    logic [`RSPI_LVL_W-1:0]     limit_r;     // Buffer level limit.

    // Edges only count while the frame strobe is low.
    // sample rise, shift fall
    wire         rise_w      = sclk_s & ~sclk_d_r & ~sel_n_s;
    wire         fall_w      = ~sclk_s & sclk_d_r & ~sel_n_s;
    wire         byte_done_w = rise_w & (bit_cnt_r == 3'h7) & (state_r != RSPI_IDLE);
    wire [7:0]   byte_w      = {sh_in_r[6:0], mosi_s};
    wire         rw_w        = byte_w[`RSPI_RW_BIT];
    wire         short_w     = ({1'b0, byte_w[6:0]} < `RSPI_SHORT_LIMIT);
    wire [`RSPI_ADDR_W-1:0] next_addr_w = addr_inc(addr_r);
    wire [7:0]   rd_short_w  = bank_r[{1'b0, byte_w[6:0]}];
    wire [7:0]   rd_low_w    = bank_r[byte_w];
    wire [7:0]   rd_next_w   = bank_r[next_addr_w[7:0]];

    // ------------------------------------------------------------------------
    // Status word, cell n in bit n
    // ------------------------------------------------------------------------
    logic [15:0] stat_w;
    assign stat_w = {1'b0, aux_converter_irq_i, slow_oscillator_irq_i, wakeup_irq_i,
                     xtal_running_i, radio_event_i, power_irq_i, supply_ok_i,
                     buffer_empty_i, buffer_full_i,
                     (buffer_fill_level_i > limit_r), (buffer_space_left_i > limit_r),
                     buffer_overflow_i, buffer_overflow_i, pll_lock_i, rdy_s};

    // MISO is the head of the outgoing shift register.
    // read data on MISO
    assign miso_o = out_sh_r[7];

    // ------------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------------
    // Access is not gated by any power mode, only by the ready level.
    // every mode served
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r     <= RSPI_IDLE;
            bit_cnt_r   <= 3'h0;
            sh_in_r     <= 8'h00;
            out_sh_r    <= 8'h00;
            pend_r      <= 8'h00;
            wr_r        <= 1'b0;
            addr_r      <= `RSPI_ADDR_W'(0);
            stat_snap_r <= 16'h0000;
        end else if (!rdy_s || sel_n_s) begin
            state_r   <= RSPI_IDLE;
            bit_cnt_r <= 3'h0;
            out_sh_r  <= 8'h00;
        end else begin
            case (state_r)
                RSPI_IDLE: begin
                    // Strobe low and ready: the first status cell appears at once,
                    // which is also how a host polling after wakeup sees MISO rise.
                    // status during address
                    state_r     <= RSPI_ADDR1;
                    bit_cnt_r   <= 3'h0;
                    out_sh_r    <= rev8(stat_w[7:0]);
                    stat_snap_r <= stat_w;
                end
                default: begin
                    if (rise_w) begin
                        sh_in_r   <= byte_w;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                    end
                    // A wrapped bit counter marks a byte boundary on the fall.
                    if (fall_w) begin
                        out_sh_r <= (bit_cnt_r == 3'h0) ? pend_r : {out_sh_r[6:0], 1'b0};
                    end
                    if (byte_done_w) begin
                        case (state_r)
                            RSPI_ADDR1: begin
                                wr_r <= rw_w;
                                if (short_w) begin
                                    addr_r  <= {5'h00, byte_w[6:0]};
                                    state_r <= RSPI_DATA;
                                    pend_r  <= rw_w ? 8'h00 : rd_short_w;
                                end else begin
                                    addr_r  <= {byte_w[3:0], 8'h00};
                                    state_r <= RSPI_ADDR2;
                                    pend_r  <= rev8(stat_snap_r[15:8]);
                                end
                            end
                            RSPI_ADDR2: begin
                                addr_r  <= {addr_r[11:8], byte_w};
                                state_r <= RSPI_DATA;
                                pend_r  <= wr_r ? 8'h00 : rd_low_w;
                            end
                            RSPI_DATA: begin
                                addr_r <= next_addr_w;
                                pend_r <= wr_r ? 8'h00 : rd_next_w;
                            end
                            default: begin
                                state_r <= RSPI_IDLE;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------------
    // Contents are lost only on reset or when power readiness drops (the deepest off
    // state); ordinary power-down keeps them because nothing else clears.
    always_ff @(posedge clk_i) begin
        if (rst_i || !rdy_s) begin
            for (int i = 0; i < `RSPI_BANK_DEPTH; i++) begin
                bank_r[i] <= 8'h00;
            end
        end else if (byte_done_w && (state_r == RSPI_DATA) && wr_r) begin
            bank_r[addr_r[7:0]] <= byte_w;
        end
    end

    // ------------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------------
    logic        ack_r;       // Acknowledge, one cycle after the request.
    logic [31:0] dat_r;       // Registered read data.
    logic [31:0] frames_r;    // Completed frame count.
    logic [7:0]  bsel_r;      // Bank byte selected for inspection.

    wire hit_w   = wb_cyc_i & wb_stb_i & ~ack_r;
    // Writes land on the acknowledging edge, when the master samples ack.
    wire wr_go_w = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    wire frame_end_w = sel_n_s & rdy_s & (state_r != RSPI_IDLE);

    // Unmapped offsets read as zero and still acknowledge.
    wire [31:0] wb_rd_w =
        (wb_adr_i == `RSPI_OFS_LIMIT)  ? {23'h00_0000, limit_r} :
        (wb_adr_i == `RSPI_OFS_STATUS) ? {16'h0000, stat_w} :
        (wb_adr_i == `RSPI_OFS_FRAMES) ? frames_r :
        (wb_adr_i == `RSPI_OFS_ADDR)   ? {20'h0_0000, addr_r} :
        (wb_adr_i == `RSPI_OFS_BSEL)   ? {24'h00_0000, bsel_r} :
        (wb_adr_i == `RSPI_OFS_BDATA)  ? {24'h00_0000, bank_r[bsel_r]} : 32'h0000_0000;

    // Bus handshake and read data capture.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= hit_w;
            if (hit_w) begin
                dat_r <= wb_rd_w;
            end
        end
    end

    // Writable registers honour the byte lanes they occupy.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            limit_r <= `RSPI_LIMIT_RST;
            bsel_r  <= `RSPI_BSEL_RST;
        end else if (wr_go_w) begin
            if (wb_adr_i == `RSPI_OFS_LIMIT) begin
                if (wb_sel_i[0]) limit_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) limit_r[8]   <= wb_dat_i[8];
            end
            if ((wb_adr_i == `RSPI_OFS_BSEL) && wb_sel_i[0]) begin
                bsel_r <= wb_dat_i[7:0];
            end
        end
    end

    // Frame counter shows the port's own activity to software.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frames_r <= 32'h0000_0000;
        end else if (frame_end_w) begin
            frames_r <= frames_r + 32'h0000_0001;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_miso_unready: assert property (!rdy_s |=> !miso_o)
        else $error("MISO high while power not ready");
    a_cell0_first: assert property ((state_r == RSPI_IDLE) && !sel_n_s && rdy_s |=> miso_o)
        else $error("Frame did not open with cell 0 high");
    a_short_addr: assert property (byte_done_w && (state_r == RSPI_ADDR1) && short_w && rdy_s
                                   |=> (state_r == RSPI_DATA) && (addr_r[11:7] == 5'h00))
        else $error("Short address form not taken");
    a_long_addr: assert property (byte_done_w && (state_r == RSPI_ADDR1) && !short_w && rdy_s
                                  |=> (state_r == RSPI_ADDR2))
        else $error("Long address form not taken");
    a_addr_step: assert property (byte_done_w && (state_r == RSPI_DATA) && rdy_s
                                  |=> addr_r == $past(addr_r) + `RSPI_ADDR_W'(1))
        else $error("Address counter did not step by one");
    a_write_store: assert property (byte_done_w && (state_r == RSPI_DATA) && wr_r && rdy_s
                                    |=> bank_r[$past(addr_r[7:0])] == $past(byte_w))
        else $error("Written byte not stored");
    a_burst_hold: assert property (byte_done_w && (state_r == RSPI_DATA) && rdy_s
                                   |=> (state_r == RSPI_DATA) [*1] ##1 (sel_n_s || state_r == RSPI_DATA))
        else $error("Burst ended while strobe low");
    a_mosi_sample: assert property (rise_w && (state_r != RSPI_IDLE) && rdy_s
                                    |=> sh_in_r[0] == $past(mosi_s))
        else $error("MOSI not sampled on rising edge");
    a_frame_close: assert property (sel_n_s |=> (state_r == RSPI_IDLE) && !miso_o)
        else $error("Frame not closed by strobe");
    a_wb_ack: assert property (hit_w |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Wishbone ack not a single cycle after request");

endmodule : rspi_port

// >>> tb/rspi_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Host that masters the serial port: mode 0, 160 ns serial clock
// ----------------------------------------------------------------------------
module rspi_host_model (
    input  wire logic clk_i,
    input  wire logic miso_i,
    output logic      sel_n_o,
    output logic      sclk_o,
    output logic      mosi_o
);
    // The serial clock stands low between frames.
    initial begin
        sel_n_o = 1'b1;
        sclk_o  = 1'b0;
        mosi_o  = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_clk

    // framed, MSB first.
    // Up to four whole bytes leave tx[31:24] first; MISO is sampled just before each rise.
    task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0000_0000;
        @(posedge clk_i);
        sel_n_o <= 1'b0;
        wait_clk(10);
        for (int i = 0; i < n * 8; i++) begin
            mosi_o <= tx[31-i];
            wait_clk(10);
            rx[31-i] = miso_i;
            sclk_o <= 1'b1;
            wait_clk(10);
            sclk_o <= 1'b0;
        end
        wait_clk(10);
        sel_n_o <= 1'b1;
        // Released data line shows the inverse, so a stale value never passes.
        mosi_o  <= ~mosi_o;
        wait_clk(20);
    endtask : frame

    // poll MISO
    // Select, then poll MISO for a bounded time until the device reports ready.
    task automatic wake(output logic up);
        up = 1'b0;
        @(posedge clk_i);
        sel_n_o <= 1'b0;
        for (int i = 0; i < 100 && !up; i++) begin
            @(posedge clk_i);
            up = miso_i;
        end
        sel_n_o <= 1'b1;
        wait_clk(20);
    endtask : wake
endmodule : rspi_host_model

// >>> tb/rspi_port_bench.sv
`timescale 1ns/1ps
`include "rspi_defines.svh"

module rspi_port_bench
    import rspi_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        pwr   = 1'b0;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack;
    logic        sel_n, sclk, mosi, miso;
    logic [8:0]  fill  = 9'h010;
    logic [8:0]  space = 9'h100;
    logic [3:0]  sel   = 4'hF;
    // Status sources {aux, slow, wakeup, xtal, radio, pirq, supply, empty, full, ovf, lock}.
    logic [10:0] src   = 11'h4D9;
    logic [31:0] rx, v;
    logic        up;
    int          bad_count = 0;
    int          checks    = 0;

    always #4 clk_i = ~clk_i;

    rspi_host_model i_host (.clk_i(clk_i), .miso_i(miso), .sel_n_o(sel_n), .sclk_o(sclk), .mosi_o(mosi));

    // Status sources start at known levels and are all flipped late in the run.
    rspi_port i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .sel_n_i(sel_n), .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso),
        .power_ready_i(pwr), .pll_lock_i(src[0]), .buffer_overflow_i(src[1]), .buffer_full_i(src[2]),
        .buffer_empty_i(src[3]), .buffer_fill_level_i(fill), .buffer_space_left_i(space),
        .supply_ok_i(src[4]), .power_irq_i(src[5]), .radio_event_i(src[6]), .xtal_running_i(src[7]),
        .wakeup_irq_i(src[8]), .slow_oscillator_irq_i(src[9]), .aux_converter_irq_i(src[10]),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

    // Classic single cycle; the request holds until ack is seen at an edge.
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb_cycle

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------------
    // Watchdog: the sequence needs well under 20,000 cycles.
    // ------------------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        print_verdict();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_cycle(1'b0, `RSPI_OFS_LIMIT, 32'h0000_0000, v);
        check(v, 32'h0000_0080);
        wb_cycle(1'b0, 8'h1C, 32'h0000_0000, v);
        check(v, 32'h0000_0000);
        // documented addresses only
        // Power not ready: frame ignored and MISO held low.
        i_host.frame(2, 32'h0500_0000, rx);
        check(rx, 32'h0000_0000);
        pwr <= 1'b1;
        i_host.wake(up);
        check({31'h0, up}, 32'h0000_0001);
        // Short burst write of two bytes; status byte 1100_1001 during the address.
        i_host.frame(3, 32'h85A5_3C00, rx);
        check(rx, 32'hC900_0000);
        wb_cycle(1'b1, `RSPI_OFS_BSEL, 32'h0000_0005, v);
        wb_cycle(1'b0, `RSPI_OFS_BDATA, 32'h0000_0000, v);
        check(v, 32'h0000_00A5);
        wb_cycle(1'b1, `RSPI_OFS_BSEL, 32'h0000_0006, v);
        wb_cycle(1'b0, `RSPI_OFS_BDATA, 32'h0000_0000, v);
        check(v, 32'h0000_003C);
        // Short read past sixteen bits; the third byte was cleared at power-up.
        i_host.frame(4, 32'h0500_0000, rx);
        check(rx, 32'hC9A5_3C00);
        // Long write at 0x080; second status byte 1011_0010 during byte two.
        i_host.frame(4, 32'hF080_5AC3, rx);
        check(rx, 32'hC9B2_0000);
        i_host.frame(4, 32'h7080_0000, rx);
        check(rx, 32'hC9B2_5AC3);
        // Five frames so far: the wakeup poll and four transfers.
        wb_cycle(1'b0, `RSPI_OFS_FRAMES, 32'h0000_0000, v);
        check(v, 32'h0000_0005);
        // Limit equal to space and one below fill flips both threshold cells.
        wb_cycle(1'b1, `RSPI_OFS_LIMIT, 32'h0000_0100, v);
        fill <= 9'h101;
        i_host.frame(1, 32'h0500_0000, rx);
        check(rx, 32'hC500_0000);
        // Every status source flipped: cells seen on the bus and on the wire.
        src <= 11'h326;
        wb_cycle(1'b0, `RSPI_OFS_STATUS, 32'h0000_0000, v);
        check(v, 32'h0000_326D);
        i_host.frame(2, 32'h7000_0000, rx);
        check(rx, 32'hB64C_0000);
        // Only byte lane 0 enabled: bit 8 of the limit keeps its value.
        sel <= 4'h1;
        wb_cycle(1'b1, `RSPI_OFS_LIMIT, 32'h0000_00FF, v);
        sel <= 4'hF;
        wb_cycle(1'b0, `RSPI_OFS_LIMIT, 32'h0000_0000, v);
        check(v, 32'h0000_01FF);
        // Bank survives frames while powered, and is lost once readiness drops.
        wb_cycle(1'b0, `RSPI_OFS_BDATA, 32'h0000_0000, v);
        check(v, 32'h0000_003C);
        pwr <= 1'b0;
        wb_cycle(1'b0, `RSPI_OFS_FRAMES, 32'h0000_0000, v);
        check(v, 32'h0000_0007);
        wb_cycle(1'b0, `RSPI_OFS_BDATA, 32'h0000_0000, v);
        check(v, 32'h0000_0000);
        print_verdict();
    end
endmodule : rspi_port_bench
